//--- hw/slpc_defines.vh
// Constants of the serial link parameter register bank.
// Assumes inclusion by bare name from the design files.
`ifndef SLPC_DEFINES_VH
`define SLPC_DEFINES_VH

// Register offsets on the serial configuration port
`define SLPC_ADDR_W           15
`define SLPC_OFS_LANE_CNT     15'h0453
`define SLPC_OFS_OCT_M1       15'h0454
`define SLPC_OFS_FRM_MF       15'h0455
`define SLPC_OFS_CONV         15'h0456
`define SLPC_OFS_CTRL_RES     15'h0457
`define SLPC_OFS_SUBCLASS     15'h0458
`define SLPC_OFS_VERSION      15'h0459
`define SLPC_OFS_DENSITY      15'h045a
`define SLPC_OFS_DESKEW       15'h046c
`define SLPC_OFS_OCT_DIRECT   15'h0476
`define SLPC_OFS_LANE_EN      15'h047d

// Field positions
`define SLPC_SCRAMBLE_BIT     7
`define SLPC_HIGH_DENS_BIT    7
`define SLPC_UPPER3_HI        7
`define SLPC_UPPER3_LO        5
`define SLPC_CTRL_BITS_HI     7
`define SLPC_CTRL_BITS_LO     6
`define SLPC_LOW5_HI          4
`define SLPC_LOW5_LO          0

// Reset values: a two-lane, four-octet setting, scrambling off
`define SLPC_RST_LANE_CNT     8'h01
`define SLPC_RST_OCT_M1       8'h03
`define SLPC_RST_FRM_MF       8'h1f
`define SLPC_RST_CONV         8'h03
`define SLPC_RST_CTRL_RES     8'h0f
`define SLPC_RST_SUBCLASS     8'h0f
`define SLPC_RST_VERSION      8'h20
`define SLPC_RST_DENSITY      8'h00
`define SLPC_RST_DESKEW       8'h03
`define SLPC_RST_OCT_DIRECT   8'h04
`define SLPC_RST_LANE_EN      8'h03

// Field codes
`define SLPC_VERSION_B        3'h1
`define SLPC_SUBCLASS_0       3'h0
`define SLPC_SUBCLASS_1       3'h1

// Serial frame: instruction bits and data bits
`define SLPC_INSTR_BITS       5'd16
`define SLPC_DATA_BITS        5'd8

`endif

//--- hw/slpc_sync.v
// Two flip-flop synchroniser for a group of pin levels.
// Assumes inputs asynchronous to clk; only the second stage is read outside.
`timescale 1ns/1ps

module slpc_sync #(
   parameter WIDTH = 3,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input  wire             clk,
   input  wire             reset_n,
   input  wire [WIDTH-1:0] d,
   output reg  [WIDTH-1:0] q
);

   reg [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always @(posedge clk) begin
      if (!reset_n) begin
         meta_r <= INIT;
         q      <= INIT;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule // slpc_sync

//--- hw/slpc_param_regs.v
// Link parameter register bank reached over a serial configuration port.
// Assumes a 4-wire port: chip select low, sclk idle low, MSB first,
// sclk period of at least eight clk periods.
//
// Notes on behaviour
// - Bit 7 of lane-count register turns descrambling on when set.
// - Low five lane-count bits hold lanes minus one.
// - Primary octets-per-frame register holds octets minus one.
// - Secondary octets-per-frame register holds octets directly.
// - Frames-per-multiframe five-bit field holds count minus one.
// - Converters-per-link register holds converter count minus one.
// - Subclass field in bits 7:5; bits 4:0 hold sample bits minus one.
// - Version field must read 1; low bits hold samples minus one.
// - Bit 7 selects high density; host writes zero control words.
// - Deskew applies to each enabled lane whose mask bit is set.
// - Each set lane-enable bit enables one link lane.
`timescale 1ns/1ps
`include "slpc_defines.vh"

module slpc_param_regs (
   input  wire       clk,
   input  wire       reset_n,
   input  wire       spi_cs_n,
   input  wire       spi_sclk,
   input  wire       spi_sdi,
   output reg        spi_sdo_r,
   output reg        spi_sdo_oe_n_r,
   output reg        scramble_en_r,
   output reg  [4:0] lanes_m1_r,
   output reg  [7:0] octets_m1_r,
   output reg  [4:0] frames_m1_r,
   output reg  [7:0] converters_m1_r,
   output reg  [1:0] ctrl_bits_r,
   output reg  [4:0] resolution_m1_r,
   output reg  [2:0] subclass_r,
   output reg  [4:0] sample_bits_m1_r,
   output reg  [2:0] version_r,
   output reg  [4:0] samples_m1_r,
   output reg        high_density_r,
   output reg  [4:0] ctrl_words_r,
   output reg  [7:0] deskew_mask_r,
   output reg  [7:0] octets_direct_r,
   output reg  [7:0] lane_enable_r,
   output reg  [5:0] lane_count_r,
   output reg  [8:0] octets_per_frame_r,
   output reg  [5:0] frames_per_mf_r,
   output reg  [8:0] converters_r,
   output reg  [7:0] deskew_lanes_r,
   output reg        octets_mismatch_r,
   output reg        version_ok_r,
   output reg        subclass_ok_r
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and sclk edges

   localparam ST_IDLE  = 2'b00;
   localparam ST_INSTR = 2'b01;
   localparam ST_DATA  = 2'b10;

   wire [2:0]  pins_s;
   wire        cs_n_s;
   wire        sclk_s;
   wire        sdi_s;
   reg         sclk_d_r;
   wire        sclk_rise;
   wire        sclk_fall;

   reg  [1:0]  state_r;
   reg  [4:0]  bit_cnt_r;
   reg  [15:0] in_sr_r;
   reg  [7:0]  out_sr_r;
   reg  [14:0] addr_r;
   reg         read_r;
   wire [15:0] in_word;
   wire [7:0]  wr_data;
   wire        instr_done;
   wire        byte_done;
   wire        wr_strobe;
   wire [14:0] addr_inc;
   wire [8:0]  lanes_p1;
   wire [8:0]  frames_p1;

   // Whole-register reset images, split into fields by part-select
   localparam [7:0] RST_LANE_CNT = `SLPC_RST_LANE_CNT;
   localparam [7:0] RST_FRM_MF   = `SLPC_RST_FRM_MF;
   localparam [7:0] RST_CTRL_RES = `SLPC_RST_CTRL_RES;
   localparam [7:0] RST_SUBCLASS = `SLPC_RST_SUBCLASS;
   localparam [7:0] RST_VERSION  = `SLPC_RST_VERSION;
   localparam [7:0] RST_DENSITY  = `SLPC_RST_DENSITY;

   slpc_sync #(
      .WIDTH (3),
      .INIT  (3'b001)
   ) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .d       ({spi_sdi, spi_sclk, spi_cs_n}),
      .q       (pins_s)
   );

   assign cs_n_s = pins_s[0];
   assign sclk_s = pins_s[1];
   assign sdi_s  = pins_s[2];

   // Delayed sclk for edge detection
   always @(posedge clk) begin
      if (!reset_n) begin
         sclk_d_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk_s;
      end
   end

   assign sclk_rise = !cs_n_s && sclk_s && !sclk_d_r;
   assign sclk_fall = !cs_n_s && !sclk_s && sclk_d_r;

   ////////////////////////////////////////////////////////////////////////
   // Read decode, used after the instruction and after each byte

   function [7:0] read_reg;
      input [14:0] a;
      begin
         case (a)
            `SLPC_OFS_LANE_CNT:   read_reg = {scramble_en_r, 2'b00, lanes_m1_r};
            `SLPC_OFS_OCT_M1:     read_reg = octets_m1_r;
            `SLPC_OFS_FRM_MF:     read_reg = {3'b000, frames_m1_r};
            `SLPC_OFS_CONV:       read_reg = converters_m1_r;
            `SLPC_OFS_CTRL_RES:   read_reg = {ctrl_bits_r, 1'b0, resolution_m1_r};
            `SLPC_OFS_SUBCLASS:   read_reg = {subclass_r, sample_bits_m1_r};
            `SLPC_OFS_VERSION:    read_reg = {version_r, samples_m1_r};
            `SLPC_OFS_DENSITY:    read_reg = {high_density_r, 2'b00, ctrl_words_r};
            `SLPC_OFS_DESKEW:     read_reg = deskew_mask_r;
            `SLPC_OFS_OCT_DIRECT: read_reg = octets_direct_r;
            `SLPC_OFS_LANE_EN:    read_reg = lane_enable_r;
            default:              read_reg = 8'h00;
         endcase
      end
   endfunction

   // Widen a minus-one field to its count
   function [8:0] plus_one;
      input [7:0] v;
      begin
         plus_one = {1'b0, v} + 9'h001;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Serial frame sequencing

   assign in_word    = {in_sr_r[14:0], sdi_s};
   assign wr_data    = in_word[7:0];
   assign instr_done = sclk_rise && (state_r == ST_INSTR) && (bit_cnt_r == `SLPC_INSTR_BITS - 5'd1);
   assign byte_done  = sclk_rise && (state_r == ST_DATA) && (bit_cnt_r == `SLPC_DATA_BITS - 5'd1);
   assign wr_strobe  = byte_done && !read_r;
   assign addr_inc   = addr_r + 15'h0001;
   assign lanes_p1   = plus_one({3'b000, lanes_m1_r});
   assign frames_p1  = plus_one({3'b000, frames_m1_r});

   // Instruction, address and data shifting; address steps per byte
   always @(posedge clk) begin
      if (!reset_n) begin
         state_r   <= ST_IDLE;
         bit_cnt_r <= 5'd0;
         in_sr_r   <= 16'h0000;
         out_sr_r  <= 8'h00;
         addr_r    <= 15'h0000;
         read_r    <= 1'b0;
      end else if (cs_n_s) begin
         state_r   <= ST_IDLE;
         bit_cnt_r <= 5'd0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               state_r   <= ST_INSTR;
               bit_cnt_r <= 5'd0;
            end
            ST_INSTR: begin
               if (sclk_rise) begin
                  in_sr_r <= in_word;
                  if (instr_done) begin
                     state_r   <= ST_DATA;
                     bit_cnt_r <= 5'd0;
                     read_r    <= in_word[15];
                     addr_r    <= in_word[14:0];
                     out_sr_r  <= read_reg(in_word[14:0]);
                  end else begin
                     bit_cnt_r <= bit_cnt_r + 5'd1;
                  end
               end
            end
            ST_DATA: begin
               if (sclk_rise) begin
                  in_sr_r <= in_word;
                  if (byte_done) begin
                     bit_cnt_r <= 5'd0;
                     addr_r    <= addr_inc;
                     out_sr_r  <= read_reg(addr_inc);
                  end else begin
                     bit_cnt_r <= bit_cnt_r + 5'd1;
                  end
               end else if (sclk_fall && read_r) begin
                  out_sr_r <= {out_sr_r[6:0], 1'b0};
               end
            end
            default: begin
               state_r   <= ST_IDLE;
               bit_cnt_r <= 5'd0;
            end
         endcase
      end
   end

   // Read data driven on falling sclk; enable low only while reading
   always @(posedge clk) begin
      if (!reset_n) begin
         spi_sdo_r      <= 1'b0;
         spi_sdo_oe_n_r <= 1'b1;
      end else begin
         spi_sdo_oe_n_r <= !((state_r == ST_DATA) && read_r && !cs_n_s);
         if (cs_n_s) begin
            spi_sdo_r <= 1'b0;
         end else if (sclk_fall && (state_r == ST_DATA) && read_r) begin
            spi_sdo_r <= out_sr_r[7];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes

   always @(posedge clk) begin
      if (!reset_n) begin
         scramble_en_r    <= RST_LANE_CNT[`SLPC_SCRAMBLE_BIT];
         lanes_m1_r       <= RST_LANE_CNT[`SLPC_LOW5_HI:`SLPC_LOW5_LO];
         octets_m1_r      <= `SLPC_RST_OCT_M1;
         frames_m1_r      <= RST_FRM_MF[`SLPC_LOW5_HI:`SLPC_LOW5_LO];
         converters_m1_r  <= `SLPC_RST_CONV;
         ctrl_bits_r      <= RST_CTRL_RES[`SLPC_CTRL_BITS_HI:`SLPC_CTRL_BITS_LO];
         resolution_m1_r  <= RST_CTRL_RES[`SLPC_LOW5_HI:`SLPC_LOW5_LO];
         subclass_r       <= RST_SUBCLASS[`SLPC_UPPER3_HI:`SLPC_UPPER3_LO];
         sample_bits_m1_r <= RST_SUBCLASS[`SLPC_LOW5_HI:`SLPC_LOW5_LO];
         version_r        <= RST_VERSION[`SLPC_UPPER3_HI:`SLPC_UPPER3_LO];
         samples_m1_r     <= RST_VERSION[`SLPC_LOW5_HI:`SLPC_LOW5_LO];
         high_density_r   <= RST_DENSITY[`SLPC_HIGH_DENS_BIT];
         ctrl_words_r     <= RST_DENSITY[`SLPC_LOW5_HI:`SLPC_LOW5_LO];
         deskew_mask_r    <= `SLPC_RST_DESKEW;
         octets_direct_r  <= `SLPC_RST_OCT_DIRECT;
         lane_enable_r    <= `SLPC_RST_LANE_EN;
      end else if (wr_strobe) begin
         case (addr_r)
            `SLPC_OFS_LANE_CNT: begin
               scramble_en_r <= wr_data[`SLPC_SCRAMBLE_BIT];
               lanes_m1_r    <= wr_data[`SLPC_LOW5_HI:`SLPC_LOW5_LO];
            end
            `SLPC_OFS_OCT_M1:  octets_m1_r     <= wr_data;
            `SLPC_OFS_FRM_MF:  frames_m1_r     <= wr_data[`SLPC_LOW5_HI:`SLPC_LOW5_LO];
            `SLPC_OFS_CONV:    converters_m1_r <= wr_data;
            `SLPC_OFS_CTRL_RES: begin
               // Stored as written; host keeps these at zero and 16 bits
               ctrl_bits_r     <= wr_data[`SLPC_CTRL_BITS_HI:`SLPC_CTRL_BITS_LO];
               resolution_m1_r <= wr_data[`SLPC_LOW5_HI:`SLPC_LOW5_LO];
            end
            `SLPC_OFS_SUBCLASS: begin
               subclass_r       <= wr_data[`SLPC_UPPER3_HI:`SLPC_UPPER3_LO];
               sample_bits_m1_r <= wr_data[`SLPC_LOW5_HI:`SLPC_LOW5_LO];
            end
            `SLPC_OFS_VERSION: begin
               version_r    <= wr_data[`SLPC_UPPER3_HI:`SLPC_UPPER3_LO];
               samples_m1_r <= wr_data[`SLPC_LOW5_HI:`SLPC_LOW5_LO];
            end
            `SLPC_OFS_DENSITY: begin
               high_density_r <= wr_data[`SLPC_HIGH_DENS_BIT];
               ctrl_words_r   <= wr_data[`SLPC_LOW5_HI:`SLPC_LOW5_LO];
            end
            `SLPC_OFS_DESKEW:     deskew_mask_r   <= wr_data;
            `SLPC_OFS_OCT_DIRECT: octets_direct_r <= wr_data;
            `SLPC_OFS_LANE_EN:    lane_enable_r   <= wr_data;
            default: begin
               lane_enable_r <= lane_enable_r;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decoded link parameters, one cycle behind the registers

   always @(posedge clk) begin
      if (!reset_n) begin
         lane_count_r       <= 6'd0;
         octets_per_frame_r <= 9'd0;
         frames_per_mf_r    <= 6'd0;
         converters_r       <= 9'd0;
         deskew_lanes_r     <= 8'h00;
         octets_mismatch_r  <= 1'b0;
         version_ok_r       <= 1'b0;
         subclass_ok_r      <= 1'b0;
      end else begin
         lane_count_r       <= lanes_p1[5:0];
         octets_per_frame_r <= plus_one(octets_m1_r);
         frames_per_mf_r    <= frames_p1[5:0];
         converters_r       <= plus_one(converters_m1_r);
         // Deskew only lanes that are also enabled
         deskew_lanes_r     <= deskew_mask_r & lane_enable_r;
         // Direct count must equal minus-one count plus one
         octets_mismatch_r  <= plus_one(octets_m1_r) != {1'b0, octets_direct_r};
         version_ok_r       <= version_r == `SLPC_VERSION_B;
         subclass_ok_r      <= (subclass_r == `SLPC_SUBCLASS_0) ||
                               (subclass_r == `SLPC_SUBCLASS_1);
      end
   end

endmodule // slpc_param_regs

//--- verif/slpc_param_regs_properties.sv
// Checker: decoded link parameters against their stored fields.
// Assumes a bind into slpc_param_regs; sees its ports only.
`timescale 1ns/1ps
module slpc_param_regs_chk (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       spi_sdo_oe_n_r,
   input wire logic       scramble_en_r,
   input wire logic [4:0] lanes_m1_r,
   input wire logic [5:0] lane_count_r,
   input wire logic [7:0] octets_m1_r,
   input wire logic [8:0] octets_per_frame_r,
   input wire logic [7:0] octets_direct_r,
   input wire logic       octets_mismatch_r,
   input wire logic [4:0] frames_m1_r,
   input wire logic [5:0] frames_per_mf_r,
   input wire logic [7:0] converters_m1_r,
   input wire logic [8:0] converters_r,
   input wire logic [2:0] subclass_r,
   input wire logic       subclass_ok_r,
   input wire logic [2:0] version_r,
   input wire logic       version_ok_r,
   input wire logic [7:0] deskew_mask_r,
   input wire logic [7:0] lane_enable_r,
   input wire logic [7:0] deskew_lanes_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////
   // Decoded outputs follow their fields one clock later
   lane_count_a: assert property ($past(reset_n) |-> lane_count_r == $past(lanes_m1_r) + 6'd1)
      else $error("lane count wrong");
   octet_count_a: assert property ($past(reset_n) |-> octets_per_frame_r == $past(octets_m1_r) + 9'd1)
      else $error("octet count wrong");
   octet_mismatch_a: assert property ($past(reset_n) |->
      octets_mismatch_r == ($past(octets_m1_r) + 9'd1 != {1'b0, $past(octets_direct_r)})) else $error("mismatch wrong");
   frame_count_a: assert property ($past(reset_n) |-> frames_per_mf_r == $past(frames_m1_r) + 6'd1)
      else $error("frame count wrong");
   converter_count_a: assert property ($past(reset_n) |-> converters_r == $past(converters_m1_r) + 9'd1)
      else $error("converter count wrong");
   subclass_flag_a: assert property ($past(reset_n) |-> subclass_ok_r == ($past(subclass_r) <= 3'h1))
      else $error("subclass flag wrong");
   version_flag_a: assert property ($past(reset_n) |-> version_ok_r == ($past(version_r) == 3'h1))
      else $error("version flag wrong");
   deskew_lanes_a: assert property ($past(reset_n) |->
      deskew_lanes_r == ($past(deskew_mask_r) & $past(lane_enable_r))) else $error("deskew lanes wrong");
   cover property (!spi_sdo_oe_n_r);
   cover property ($rose(scramble_en_r));
   cover property (octets_mismatch_r && !version_ok_r);
endmodule // slpc_param_regs_chk

bind slpc_param_regs slpc_param_regs_chk i_chk (.*);

//--- verif/slpc_testbench.sv
// Testbench: drives the serial port of the parameter bank, checks fields,
// decoded values and readback. Assumes a 25 MHz clk and 10-clk sclk bits.
`timescale 1ns/1ps
module testbench;
   logic        clk = 0, reset_n = 0, spi_cs_n = 1, spi_sclk = 0, spi_sdi = 0;
   logic        spi_sdo_r, spi_sdo_oe_n_r, scramble_en_r, high_density_r, octets_mismatch_r, version_ok_r, subclass_ok_r;
   logic [1:0]  ctrl_bits_r;
   logic [2:0]  subclass_r, version_r;
   logic [4:0]  lanes_m1_r, frames_m1_r, resolution_m1_r, sample_bits_m1_r, samples_m1_r, ctrl_words_r;
   logic [5:0]  lane_count_r, frames_per_mf_r;
   logic [7:0]  octets_m1_r, converters_m1_r, deskew_mask_r, octets_direct_r, lane_enable_r, deskew_lanes_r;
   logic [8:0]  octets_per_frame_r, converters_r;
   logic [7:0]  wbuf [8], rbuf [8], shadow [11];
   int          miscompares = 0, checks_done = 0, cyc = 0;
   localparam logic [14:0] ADDR_T [11] = '{15'h453, 15'h454, 15'h455, 15'h456, 15'h457, 15'h458, 15'h459,
                                          15'h45a, 15'h46c, 15'h476, 15'h47d};
   localparam logic [7:0]  MASK_T [11] = '{8'h9f, 8'hff, 8'h1f, 8'hff, 8'hdf, 8'hff, 8'hff, 8'h9f, 8'hff, 8'hff, 8'hff};
   localparam logic [7:0]  RST_T [11] = '{8'h01, 8'h03, 8'h1f, 8'h03, 8'h0f, 8'h0f, 8'h20, 8'h00, 8'h03, 8'h04, 8'h03};
   localparam logic [87:0] MODE_T [4] = '{88'h81031f030f2f2000030403, 88'h03000f010f0f20800f010f,
                                         88'h83011f010f2f21000f020f, 88'h01010f010f0f2000030203};

   slpc_param_regs i_dut (.*);

   // Clock and hang guard
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         miscompares++;
         $display("unexpected timeout");
         results;
      end
   end
   ////////////////////////////////////////////////////////////
   // Helpers: inputs change 2 ns after a rising edge
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // One bit: data set while sclk low, sdo read just before the rise
   task automatic sbit(input logic b, output logic s);
      spi_sdi = b;
      tk(5);
      s = spi_sdo_r;
      spi_sclk = 1;
      tk(5);
      spi_sclk = 0;
   endtask
   // Instruction then nb data bits from wbuf; read bits land in rbuf
   task automatic frame(input logic rd, input logic [14:0] a, input int nb);
      logic [15:0] ins;
      logic        s;
      ins = {rd, a};
      spi_cs_n = 0;
      tk(4);
      for (int i = 15; i >= 0; i--) sbit(ins[i], s);
      for (int i = 0; i < nb; i++) begin
         sbit(wbuf[i / 8][7 - i % 8], s);
         rbuf[i / 8][7 - i % 8] = s;
      end
      chk("sdo enable", {8'h00, !rd}, spi_sdo_oe_n_r);
      spi_cs_n = 1;
      spi_sdi = ~spi_sdi;
      tk(5);
      chk("sdo enable idle", 9'h001, spi_sdo_oe_n_r);
   endtask
   task automatic wr(input int k, input logic [7:0] v);
      wbuf[0] = v;
      frame(1'b0, ADDR_T[k], 8);
      shadow[k] = v;
   endtask
   task automatic rdchk(input int k);
      frame(1'b1, ADDR_T[k], 8);
      chk("readback", shadow[k] & MASK_T[k], rbuf[0]);
   endtask
   // Field and decoded outputs against the shadow copy
   task automatic chk_ports;
      tk(2);
      chk("lane field", shadow[0] & 8'h9f, {scramble_en_r, 2'b00, lanes_m1_r});
      chk("lane count", shadow[0][4:0] + 6'd1, lane_count_r);
      chk("octets field", shadow[1], octets_m1_r);
      chk("octets", shadow[1] + 9'd1, octets_per_frame_r);
      chk("octets direct", shadow[9], octets_direct_r);
      chk("mismatch", shadow[1] + 9'd1 != {1'b0, shadow[9]}, octets_mismatch_r);
      chk("frames field", shadow[2] & 8'h1f, {3'b000, frames_m1_r});
      chk("frames", shadow[2][4:0] + 6'd1, frames_per_mf_r);
      chk("converters field", shadow[3], converters_m1_r);
      chk("converters", shadow[3] + 9'd1, converters_r);
      chk("deskew mask", shadow[8], deskew_mask_r);
      chk("resolution", shadow[4] & 8'hdf, {ctrl_bits_r, 1'b0, resolution_m1_r});
      chk("subclass", shadow[5], {subclass_r, sample_bits_m1_r});
      chk("subclass ok", shadow[5][7:5] <= 3'h1, subclass_ok_r);
      chk("version", shadow[6], {version_r, samples_m1_r});
      chk("version ok", shadow[6][7:5] == 3'h1, version_ok_r);
      chk("density", shadow[7] & 8'h9f, {high_density_r, 2'b00, ctrl_words_r});
      chk("deskew lanes", shadow[8] & shadow[10], deskew_lanes_r);
      chk("lane enable", shadow[10], lane_enable_r);
   endtask
   task automatic results;
      $display("checks %0d, miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int r;
      logic [7:0] v;
      void'($urandom(32'h127b234c));
      shadow = RST_T;
      tk(16);
      reset_n = 1;
      tk(4);
      chk_ports;
      for (int k = 0; k < 11; k++) rdchk(k);
      $display("test reset values done");
      // Modes 0 to 3: eight streamed bytes, then deskew mask, direct octets and lane enable
      for (int m = 0; m < 4; m++) begin
         for (int k = 0; k < 8; k++) wbuf[k] = MODE_T[m][87 - 8 * k -: 8];
         frame(1'b0, ADDR_T[0], 64);
         for (int k = 0; k < 8; k++) shadow[k] = wbuf[k];
         for (int k = 8; k < 11; k++) wr(k, MODE_T[m][87 - 8 * k -: 8]);
         chk_ports;
      end
      $display("test mode settings done");
      // Random bytes to mapped places; unmapped ones ignored
      repeat (20) begin
         r = $urandom % 11;
         v = 8'($urandom);
         // Host keeps its own field obligations in random traffic
         if (r == 4) v = 8'h0f;
         if (r == 6) v[7:5] = 3'h1;
         if (r == 7) v[4:0] = 5'h00;
         wr(r, v);
         rdchk(r);
         wbuf[0] = 8'($urandom);
         frame(1'b0, 15'h7000 | 15'($urandom % 4096), 8);
         frame(1'b1, 15'h7000 | 15'($urandom % 4096), 8);
         chk("unmapped read", 9'h0, rbuf[0]);
         chk_ports;
      end
      $display("test random access done");
      // Partial byte dropped, then inconsistent settings flagged
      wbuf[0] = ~shadow[0];
      frame(1'b0, ADDR_T[0], 4);
      wr(5, 8'h4f);
      wr(6, 8'he1);
      wr(1, 8'h00);
      wr(9, 8'h04);
      chk_ports;
      $display("test partial and flags done");
      reset_n = 0;
      tk(16);
      reset_n = 1;
      shadow = RST_T;
      tk(4);
      chk_ports;
      $display("test second reset done");
      results;
   end
endmodule // testbench
